// *** include/serial_port_pkg.sv ***
// constants, types and register map of the serial port core
// assumes one 200 MHz clock and a simple strobe register port
package serial_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, word index on the register port
  localparam logic [2:0] CTRL_OFFSET = 3'h0;
  localparam logic [2:0] DATA_OFFSET = 3'h1;
  localparam logic [2:0] BAUD_OFFSET = 3'h2;
  localparam logic [2:0] INT_STATUS_OFFSET = 3'h3;
  localparam logic [2:0] INT_ENABLE_OFFSET = 3'h4;
  localparam logic [2:0] INT_CLEAR_OFFSET = 3'h5;
  localparam logic [2:0] PORT_LATCH_OFFSET = 3'h6;
  localparam logic [2:0] BUSY_OFFSET = 3'h7;

  // interrupt status bit positions
  localparam int INT_RX_BIT = 0;
  localparam int INT_TX_BIT = 1;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [1:0] INT_ENABLE_RESET = 2'h0;
  localparam logic [1:0] PORT_LATCH_RESET = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // timing: prescaler ticks are half shift clocks in mode 0, 1/16 bit otherwise
  localparam int MODE0_DIVIDE = 12;
  localparam int MODE2_DIVIDE = 64;
  localparam int OVERSAMPLE = 16;
  localparam logic [7:0] MODE0_RELOAD = 8'(MODE0_DIVIDE / 2 - 1);
  localparam logic [7:0] MODE2_RELOAD = 8'(MODE2_DIVIDE / OVERSAMPLE - 1);
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] LAST_SUB = 4'hf;

  // frame lengths in bits, and bit counter values at which transmit done is set
  localparam logic [3:0] MODE0_BITS = 4'h8;
  localparam logic [3:0] TX_BITS_EIGHT = 4'ha;
  localparam logic [3:0] TX_BITS_NINE = 4'hb;
  localparam logic [3:0] RX_SAMPLES = 4'ha;
  localparam logic [3:0] SYNC_LAST_BIT = 4'h1;
  localparam logic [3:0] ASYNC_LAST_DATA = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIXED = 2'b10,
    MODE_UART9_VAR = 2'b11
  } mode_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_RUN = 1'b1
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ASYNC = 2'b01,
    RX_SYNC = 2'b10
  } rx_state_type;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    mode_type mode;
    logic filter;
    logic rx_enable;
    logic tx_ninth;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage

// *** hdl/serial_port_core.sv ***
// serial port core: mode 0 shift register and three uart modes
// assumes a register master on CLOCK and asynchronous serial pins
`timescale 1ns/1ps
`default_nettype none
module serial_port_core
  import serial_port_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire bus_req_type BUS,
  output logic [7:0] RDATA,
  input wire logic RX_IN,
  output logic RX_OUT,
  output logic RX_OE,
  output logic TX_OUT,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  ctrl_type ctrl_reg;
  logic [7:0] baud_reg;
  logic [7:0] rx_hold_reg;
  logic [1:0] int_status_reg;
  logic [1:0] int_enable_reg;
  logic [1:0] port_latch_reg;
  logic [7:0] rdata_reg;
  logic m0_arm_reg;
  logic [7:0] presc_reg;
  tx_state_type tx_state_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;
  logic [3:0] tx_sub_reg;
  rx_state_type rx_state_reg;
  logic [8:0] rx_shift_reg;
  logic [3:0] rx_bits_reg;
  logic [3:0] rx_sub_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  logic tx_pin_reg;
  logic rx_out_reg;
  logic rx_oe_reg;
  mode_type mode;
  logic sync_mode;
  logic wr_ctrl;
  logic wr_data;
  logic tick;
  logic tx_bit_end;
  logic tx_fin;
  logic rx_line;
  logic rx_fall;
  logic rx_async_start;
  logic rx_sample;
  logic rx_abort;
  logic rx_fin;
  logic rx_pass;
  logic rx_load;
  logic [7:0] rx_data;
  logic [7:0] read_mux;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n_reg);

  assign mode = ctrl_reg.mode;
  assign sync_mode = (mode == MODE_SHIFT);
  assign wr_ctrl = BUS.wr && (BUS.addr == CTRL_OFFSET);
  assign wr_data = BUS.wr && (BUS.addr == DATA_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // control register; hardware sets win over a software write in the same cycle
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      ctrl_reg <= ctrl_type'(CTRL_RESET);
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_type'(BUS.wdata);
      if (tx_fin)
        ctrl_reg.tx_done <= 1'b1;
      if (rx_load)
      begin
        ctrl_reg.rx_done <= 1'b1;
        ctrl_reg.rx_ninth <= rx_line;
      end
    end
  end

  // mode 0 reception is armed only by a 0 to 1 edge of the enable bit
  // the arm is spent on the edge that leaves idle, so one byte per arm
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      m0_arm_reg <= 1'b0;
    else if (wr_ctrl && BUS.wdata[4] && !ctrl_reg.rx_enable)
      m0_arm_reg <= (BUS.wdata[7:6] == MODE_SHIFT);
    else if (rx_state_reg == RX_IDLE || !sync_mode)
      m0_arm_reg <= 1'b0;
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      baud_reg <= BAUD_RESET;
      int_enable_reg <= INT_ENABLE_RESET;
      port_latch_reg <= PORT_LATCH_RESET;
    end
    else if (BUS.wr)
    begin
      if (BUS.addr == BAUD_OFFSET)
        baud_reg <= BUS.wdata;
      if (BUS.addr == INT_ENABLE_OFFSET)
        int_enable_reg <= BUS.wdata[1:0];
      if (BUS.addr == PORT_LATCH_OFFSET)
        port_latch_reg <= BUS.wdata[1:0];
    end
  end

  // sticky events, cleared by writing ones; an event in the clear cycle stays
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      int_status_reg <= 2'h0;
    else
    begin
      if (BUS.wr && BUS.addr == INT_CLEAR_OFFSET)
        int_status_reg <= int_status_reg & ~BUS.wdata[1:0];
      if (rx_load)
        int_status_reg[INT_RX_BIT] <= 1'b1;
      if (tx_fin)
        int_status_reg[INT_TX_BIT] <= 1'b1;
    end
  end

  assign IRQ = |(int_status_reg & int_enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe, zero otherwise
  always_comb
  begin
    unique case (BUS.addr)
      CTRL_OFFSET: read_mux = ctrl_reg;
      DATA_OFFSET: read_mux = rx_hold_reg;
      BAUD_OFFSET: read_mux = baud_reg;
      INT_STATUS_OFFSET: read_mux = {6'h00, int_status_reg};
      INT_ENABLE_OFFSET: read_mux = {6'h00, int_enable_reg};
      INT_CLEAR_OFFSET: read_mux = 8'h00;
      PORT_LATCH_OFFSET: read_mux = {6'h00, port_latch_reg};
      BUSY_OFFSET: read_mux = {6'h00, rx_state_reg != RX_IDLE, tx_state_reg == TX_RUN};
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= BUS.rd ? read_mux : 8'h00;
  end

  assign RDATA = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shared prescaler; free running, so the first bit may be short by one tick
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      presc_reg <= 8'h00;
    else if (presc_reg != 8'h00)
      presc_reg <= presc_reg - 8'h01;
    else if (sync_mode)
      presc_reg <= MODE0_RELOAD;
    else if (mode == MODE_UART9_FIXED)
      presc_reg <= MODE2_RELOAD;
    else
      presc_reg <= baud_reg;
  end

  assign tick = (presc_reg == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // transmitter; a write while busy restarts with the new byte
  assign tx_bit_end = (tx_state_reg == TX_RUN) && tick &&
    (sync_mode ? tx_sub_reg[0] : tx_sub_reg == LAST_SUB);
  assign tx_fin = tx_bit_end &&
    (tx_bits_reg == (sync_mode ? SYNC_LAST_BIT : ASYNC_LAST_DATA));

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_bits_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end
    else if (wr_data)
    begin
      tx_state_reg <= TX_RUN;
      tx_sub_reg <= 4'h0;
      unique case (mode)
        MODE_SHIFT:
        begin
          tx_shift_reg <= {3'h7, BUS.wdata};
          tx_bits_reg <= MODE0_BITS;
        end
        MODE_UART8:
        begin
          tx_shift_reg <= {2'h3, BUS.wdata, 1'b0};
          tx_bits_reg <= TX_BITS_EIGHT;
        end
        MODE_UART9_FIXED, MODE_UART9_VAR:
        begin
          tx_shift_reg <= {1'b1, ctrl_reg.tx_ninth, BUS.wdata, 1'b0};
          tx_bits_reg <= TX_BITS_NINE;
        end
      endcase
    end
    else if (tx_state_reg == TX_RUN && tick)
    begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_bit_end)
      begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bits_reg <= tx_bits_reg - 4'h1;
        if (tx_bits_reg == 4'h1)
          tx_state_reg <= TX_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver; the pin reads low while its latch bit is zero
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= RX_IN;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_line;
    end
  end

  assign rx_line = rx_sync_reg && port_latch_reg[0];
  assign rx_fall = rx_prev_reg && !rx_line;
  // start does not look at the transmitter nor at a byte still held
  assign rx_async_start = (rx_state_reg == RX_IDLE) && !sync_mode &&
    ctrl_reg.rx_enable && rx_fall;
  assign rx_sample = tick && ((rx_state_reg == RX_ASYNC) ? rx_sub_reg == SAMPLE_POINT :
    (rx_state_reg == RX_SYNC) && !rx_sub_reg[0]);
  assign rx_abort = (rx_state_reg == RX_ASYNC) && (rx_bits_reg == RX_SAMPLES) && rx_line;
  assign rx_fin = rx_sample && !rx_abort && (rx_bits_reg == 4'h1);
  assign rx_data = (rx_state_reg == RX_SYNC) ? {rx_line, rx_shift_reg[8:2]} :
    rx_shift_reg[8:1];
  assign rx_pass = (rx_state_reg == RX_SYNC) || !ctrl_reg.filter || rx_line;
  assign rx_load = rx_fin && !ctrl_reg.rx_done && rx_pass;

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 9'h000;
      rx_bits_reg <= 4'h0;
      rx_sub_reg <= 4'h0;
    end
    else
    begin
      unique case (rx_state_reg)
        RX_IDLE:
        begin
          rx_sub_reg <= 4'h0;
          if (rx_async_start)
          begin
            rx_state_reg <= RX_ASYNC;
            rx_bits_reg <= RX_SAMPLES;
          end
          else if (sync_mode && m0_arm_reg)
          begin
            rx_state_reg <= RX_SYNC;
            rx_bits_reg <= MODE0_BITS;
          end
        end
        RX_ASYNC, RX_SYNC:
        begin
          if (tick)
            rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_abort && rx_sample)
            rx_state_reg <= RX_IDLE;
          else if (rx_sample)
          begin
            rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
            rx_bits_reg <= rx_bits_reg - 4'h1;
            if (rx_bits_reg == 4'h1 && rx_state_reg == RX_ASYNC)
              rx_state_reg <= RX_IDLE;
          end
          else if (tick && rx_sub_reg[0] && rx_bits_reg == 4'h0)
            rx_state_reg <= RX_IDLE;
        end
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rx_hold_reg <= 8'h00;
    else if (rx_load)
      rx_hold_reg <= rx_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins; in mode 0 the transmit pin carries the shift clock, low half first
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      tx_pin_reg <= 1'b1;
      rx_out_reg <= 1'b1;
      rx_oe_reg <= 1'b0;
    end
    else
    begin
      if (sync_mode && tx_state_reg == TX_RUN)
        tx_pin_reg <= port_latch_reg[1] && tx_sub_reg[0];
      else if (rx_state_reg == RX_SYNC)
        tx_pin_reg <= port_latch_reg[1] && rx_sub_reg[0];
      else
        tx_pin_reg <= port_latch_reg[1] && tx_shift_reg[0];
      rx_out_reg <= tx_shift_reg[0];
      rx_oe_reg <= sync_mode && (tx_state_reg == TX_RUN) && port_latch_reg[0];
    end
  end

  assign TX_OUT = tx_pin_reg;
  assign RX_OUT = rx_out_reg;
  assign RX_OE = rx_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_DUPLEX: assert property ((tx_state_reg == TX_RUN) && rx_async_start |=>
    rx_state_reg == RX_ASYNC) else $error("receiver blocked by transmitter");
  AST_BUFFERED: assert property (ctrl_reg.rx_done && rx_async_start |=>
    rx_state_reg == RX_ASYNC) else $error("receiver blocked by unread byte");
  AST_READ_DATA: assert property (BUS.rd && BUS.addr == DATA_OFFSET |=>
    RDATA == $past(rx_hold_reg)) else $error("data read not from receive holder");
  AST_WRITE_KEEPS_RX: assert property (wr_data && !rx_load |=>
    $stable(rx_hold_reg)) else $error("data write disturbed receive holder");
  AST_MODE0_DRIVE: assert property (sync_mode && tx_state_reg == TX_RUN &&
    port_latch_reg[0] |=> RX_OE) else $error("mode 0 data pin not driven");
  AST_TX_START: assert property (wr_data |=> tx_state_reg == TX_RUN &&
    tx_bits_reg != 4'h0 && tx_sub_reg == 4'h0) else $error("write did not start transmit");
  AST_TX_DONE: assert property (tx_fin |=> ctrl_reg.tx_done &&
    int_status_reg[INT_TX_BIT] && (tx_state_reg == TX_RUN || $past(sync_mode)))
    else $error("transmit done missed");
  AST_RX_DONE: assert property (rx_load |=> ctrl_reg.rx_done &&
    rx_hold_reg == $past(rx_data)) else $error("receive done or data missed");
  AST_MODE0_ONCE: assert property (rx_state_reg == RX_IDLE ##1
    rx_state_reg == RX_SYNC |-> !m0_arm_reg && ctrl_reg.rx_enable) else $error("mode 0 rearmed");
  AST_FILTER: assert property (rx_fin && rx_state_reg == RX_ASYNC && ctrl_reg.filter &&
    !rx_line |=> !ctrl_reg.rx_done || $past(ctrl_reg.rx_done)) else $error("filter failed");

  COV_TX_ASYNC: cover property (tx_fin && !sync_mode);
  COV_RX_ASYNC: cover property (rx_load && rx_state_reg == RX_ASYNC);
  COV_RX_SYNC: cover property (rx_load && rx_state_reg == RX_SYNC);
  COV_DROPPED: cover property (rx_fin && !rx_pass);

endmodule
`default_nettype wire

// *** test/serial_station.sv ***
// remote serial station: uart frames and mode 0 shift data on the shared pins
// assumes the bench resolves the shared data pin and calls these tasks
`timescale 1ns/1ps
`default_nettype none
module serial_station
(
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  // released line rests at its pull-up level
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // start, nb data bits lsb first, then the given stop level
  task automatic send(input logic [8:0] v, input int nb, input logic stp, input int per);
    @(posedge clk);
    line_out <= 1'b0;
    for (int i = 0; i <= nb; i++)
    begin
      repeat (per) @(posedge clk);
      line_out <= (i == nb) ? stp : v[i];
    end
    repeat (per) @(posedge clk);
    line_out <= 1'b1;
  endtask
  // samples mid-bit; the first bit may be short by a tick, half a bit absorbs it
  task automatic recv(output logic [8:0] v, input int nb, input int per);
    v = '0;
    @(negedge line_in);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (per) @(posedge clk);
      v[i] = line_in;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // mode 0: next bit after each falling shift clock, held past the sync delay
  task automatic shift(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      line_out <= v[i];
      @(posedge line_in);
      if (i < 7)
        @(negedge line_in);
    end
    repeat (4) @(posedge clk);
    line_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** test/serial_port_core_bench.sv ***
// self-checking bench for the serial port core
// assumes the station model on the serial pins and the strobe register port
`timescale 1ns/1ps
`default_nettype none
module serial_port_core_bench
  import serial_port_pkg::*;
;
  typedef struct packed {
    mode_type mode;
    logic filter;
    logic [7:0] data;
    logic ninth;
    logic loaded;
  } row_type;
  localparam int CEILING = 20000;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  bus_req_type bus = '0;
  logic [7:0] rdata;
  logic rx_out;
  logic rx_oe;
  logic tx_out;
  logic irq;
  logic station_out;
  logic rx_wire;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  row_type r;
  ctrl_type ctrl;
  logic [8:0] got;
  logic nine;
  int per;
  // ninth is the stop level in mode 1
  row_type rows [6] = '{
    '{MODE_UART8, 1'b0, 8'ha5, 1'b1, 1'b1},
    '{MODE_UART8, 1'b1, 8'h5a, 1'b0, 1'b0},
    '{MODE_UART8, 1'b0, 8'h0f, 1'b0, 1'b1},
    '{MODE_UART9_FIXED, 1'b0, 8'h81, 1'b0, 1'b1},
    '{MODE_UART9_VAR, 1'b1, 8'h3c, 1'b0, 1'b0},
    '{MODE_UART9_VAR, 1'b1, 8'hc3, 1'b1, 1'b1}};
  logic [10:0] resets [8] = '{{CTRL_OFFSET, CTRL_RESET}, {BAUD_OFFSET, BAUD_RESET},
    {INT_ENABLE_OFFSET, 8'h00}, {PORT_LATCH_OFFSET, 8'h03}, {INT_STATUS_OFFSET, 8'h00},
    {BUSY_OFFSET, 8'h00}, {INT_CLEAR_OFFSET, 8'h00}, {DATA_OFFSET, 8'h00}};
  always #2.5 clock = ~clock;
  // data pin is shared: the core drives it only in mode 0 transmit
  assign rx_wire = rx_oe ? rx_out : station_out;
  serial_port_core dut_u (.CLOCK(clock), .RESET_N(reset_n), .BUS(bus), .RDATA(rdata),
    .RX_IN(rx_wire), .RX_OUT(rx_out), .RX_OE(rx_oe), .TX_OUT(tx_out), .IRQ(irq));
  serial_station station_u (.clk(clock), .line_in(tx_out), .line_out(station_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask
  task automatic expect_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 check(rdata, exp);
  endtask
  // a hang ends the run as a failure
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == CEILING)
    begin
      failures = failures + 1;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    reg_write(PORT_LATCH_OFFSET, 8'h03);
    foreach (rows[i])
    begin
      r = rows[i];
      nine = (r.mode != MODE_UART8);
      per = (r.mode == MODE_UART9_FIXED) ? 64 : 16;
      ctrl = '{mode: r.mode, filter: r.filter, rx_enable: 1'b1, tx_ninth: r.ninth,
        rx_ninth: 1'b0, tx_done: 1'b0, rx_done: 1'b0};
      reg_write(CTRL_OFFSET, ctrl);
      reg_write(INT_CLEAR_OFFSET, 8'h03);
      fork
        reg_write(DATA_OFFSET, r.data);
        station_u.send({r.ninth, r.data}, nine ? 9 : 8, nine ? 1'b1 : r.ninth, per);
        station_u.recv(got, nine ? 9 : 8, per);
      join
      repeat (per) @(posedge clock);
      check(got, nine ? {r.ninth, r.data} : {1'b0, r.data});
      expect_reg(INT_STATUS_OFFSET, {6'h00, 1'b1, r.loaded});
      ctrl.tx_done = 1'b1;
      ctrl.rx_done = 1'b1;
      ctrl.rx_ninth = r.ninth;
      if (r.loaded)
      begin
        expect_reg(CTRL_OFFSET, ctrl);
        expect_reg(DATA_OFFSET, r.data);
      end
    end
    // interrupt raised, masked and cleared
    reg_write(INT_ENABLE_OFFSET, 8'h01);
    #1 check(irq, 9'h001);
    reg_write(INT_CLEAR_OFFSET, 8'h01);
    #1 check(irq, 9'h000);
    reg_write(INT_ENABLE_OFFSET, 8'h02);
    #1 check(irq, 9'h001);
    // second byte shifts in while the first still waits unread
    reg_write(CTRL_OFFSET, 8'h50);
    station_u.send(9'h011, 8, 1'b1, 16);
    fork
      station_u.send(9'h022, 8, 1'b1, 16);
      begin
        repeat (60) @(posedge clock);
        reg_write(CTRL_OFFSET, 8'h50);
      end
    join
    repeat (16) @(posedge clock);
    expect_reg(DATA_OFFSET, 8'h22);
    // unread flag still set: the holder must keep its byte
    station_u.send(9'h033, 8, 1'b1, 16);
    repeat (16) @(posedge clock);
    expect_reg(DATA_OFFSET, 8'h22);
    // mode 0 transmit, sampled at each rising shift clock
    reg_write(CTRL_OFFSET, 8'h00);
    got = '0;
    fork
      reg_write(DATA_OFFSET, 8'h96);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge tx_out);
        // clock and data pins update on the same edge; look once both settle
        #1 got[i] = rx_out & rx_oe;
      end
    join
    check(got, 9'h096);
    repeat (12) @(posedge clock);
    expect_reg(CTRL_OFFSET, 8'h02);
    // mode 0 receive armed by rx enable going high, exactly one byte
    fork
      reg_write(CTRL_OFFSET, 8'h10);
      station_u.shift(8'h6b);
    join
    repeat (12) @(posedge clock);
    expect_reg(DATA_OFFSET, 8'h6b);
    expect_reg(CTRL_OFFSET, 8'h11);
    reg_write(CTRL_OFFSET, 8'h10);
    repeat (200) @(posedge clock);
    expect_reg(CTRL_OFFSET, 8'h10);
    // reset in mid-run with state set and interrupt pending
    reg_write(INT_ENABLE_OFFSET, 8'h03);
    reg_write(BAUD_OFFSET, 8'h05);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    check({irq, tx_out, rx_oe}, 9'h002);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (resets[i])
      expect_reg(resets[i][10:8], resets[i][7:0]);
    conclude();
  end
endmodule
`default_nettype wire
